// >>> rtl/psl_loader.sv
// passive serial configuration loader, device side
// Overview of operation
// - in user mode all three lines sit high; request low starts reconfiguration
// - status held low for the power-on delay after reset
// - load-complete low after power-up, while waiting and during transfer
// - load-complete released only after the whole image arrived
// - with init-done option loaded, init-done driven low until initialization ends
// - load-complete low within 600 ns of request falling
// - status low within 600 ns of request falling
// - status low pulse lasts between 268 and 1506 us
// - status released within 1506 us after request rises
// - data captured on rising config_clock edges
// - internal oscillator: user mode 175 to 437 us after load-complete
// - user clock enabled no earlier than 4 max clock periods after load-complete
// - initialization lasts init_cycle_count clock cycles; counted on user clock only, oscillator init ends 175 us after load-complete
// - internal oscillator at most 12.5 MHz, user clock at most 125 MHz
// - user clock used only when its option bit is loaded
`timescale 1ns/1ps
`include "psl_defs.svh"

module psl_loader
    import psl_pkg::*;
#(
    parameter int IMAGE_BITS = 1024,
    parameter int POR_CYCLES = `PSL_STATUS_MIN_CYC,
    parameter int INIT_CYCLES = `PSL_INIT_CYCLES,
    parameter int STATUS_MAX_CYC = `PSL_STATUS_MAX_US * 1000 / `PSL_CLK_NS,
    parameter int CD2UM_MAX_CYC = `PSL_CD2UM_MAX_US * 1000 / `PSL_CLK_NS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic reconfig_n_in,
    input wire logic status_in,
    output logic status_out,
    output logic status_oe_out,
    input wire logic done_in,
    output logic done_out,
    output logic done_oe_out,
    output logic init_done_out,
    output logic init_done_oe_out,
    input wire logic config_clock_in,
    input wire logic config_data_in,
    input wire logic user_init_clock_in,
    output logic user_mode_out
);

    localparam int CW = `PSL_CNT_W;
    localparam logic [CW-1:0] POR_LAST = CW'(POR_CYCLES - 1);
    localparam logic [CW-1:0] STS_LAST = CW'(`PSL_STATUS_MIN_CYC - 1);
    localparam logic [CW-1:0] UM_LAST = CW'(`PSL_CD2UM_MIN_CYC - 1);
    localparam logic [CW-1:0] CU_LAST = CW'(`PSL_CD2CU_CYC - 1);
    localparam logic [CW-1:0] INIT_LAST = CW'(INIT_CYCLES - 1);
    localparam int CF2_CYC = `PSL_CF2ST0_CYC;
    localparam int STS_MIN_CYC = `PSL_STATUS_MIN_CYC;
    localparam int UM_MIN_CYC = `PSL_CD2UM_MIN_CYC;
    localparam int CU_CYC = `PSL_CD2CU_CYC;
    localparam psl_core_t CORE_RST = '{st: PSL_POR, status_oe: 1'b1, done_oe: 1'b1,
                                       default: '0};

    logic [1:0] rst_q;
    logic rst_sync_n;
    psl_core_t r;
    psl_core_t n;
    logic img_done;
    logic init_go;
    logic [7:0] opt;
    logic uclk_edge;

    // ==========================================================
    // reset release
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_q[1];

    // ==========================================================
    // link side, held in reset whenever the core is not armed
    psl_link #(
        .IMAGE_BITS(IMAGE_BITS)
    ) u_link (
        .config_clock_in(config_clock_in),
        .link_rst_n_in(r.arm),
        .config_data_in(config_data_in),
        .image_done_out(img_done),
        .init_go_out(init_go),
        .opt_out(opt)
    );

    assign uclk_edge = r.uclk_s[1] & ~r.uclk_d;

    // ==========================================================
    // sequencer, clk_in doubles as the internal oscillator, 10 MHz
    always_comb begin
        n = r;
        n.rcfg_s = {r.rcfg_s[0], reconfig_n_in};
        n.sts_s = {r.sts_s[0], status_in};
        n.done_s = {r.done_s[0], img_done};
        n.go_s = {r.go_s[0], init_go};
        n.uclk_s = {r.uclk_s[0], user_init_clock_in};
        n.uclk_d = r.uclk_s[1];
        if (r.cnt != '1) begin
            n.cnt = r.cnt + 16'h0001;
        end
        unique case (r.st)
            PSL_POR: begin
                if (r.cnt >= POR_LAST) begin
                    n.st = PSL_RESET;
                end
            end
            PSL_RESET: begin
                if (r.rcfg_s[1] && r.cnt >= STS_LAST) begin
                    n.st = PSL_LOAD;
                    n.status_oe = 1'b0;
                end
            end
            PSL_LOAD: begin
                // a status line held low outside disarms the link
                n.arm = r.sts_s[1];
                if (r.done_s[1]) begin
                    n.st = PSL_DONE;
                    n.done_oe = 1'b0;
                    n.cnt = '0;
                    n.use_uclk = opt[`PSL_OPT_USER_CLK];
                    n.init_oe = opt[`PSL_OPT_INIT_DONE];
                end
            end
            PSL_DONE: begin
                if (r.go_s[1]) begin
                    n.st = r.use_uclk ? PSL_CLK_EN : PSL_INIT;
                end
            end
            PSL_CLK_EN: begin
                if (r.cnt >= CU_LAST) begin
                    n.st = PSL_INIT;
                    n.ucnt = '0;
                end
            end
            PSL_INIT: begin
                if (r.use_uclk) begin
                    if (uclk_edge) begin
                        n.ucnt = r.ucnt + 16'h0001;
                        if (r.ucnt == INIT_LAST) begin
                            n.st = PSL_USER;
                        end
                    end
                end else if (r.cnt >= UM_LAST) begin
                    n.st = PSL_USER;
                end
                if (n.st == PSL_USER) begin
                    n.init_oe = 1'b0;
                    n.user_mode = 1'b1;
                    n.arm = 1'b0;
                end
            end
            PSL_USER: begin
                n.user_mode = 1'b1;
            end
            default: begin
                n.st = PSL_POR;
            end
        endcase
        if (!r.rcfg_s[1] && r.st != PSL_POR) begin
            n.st = PSL_RESET;
            if (r.st != PSL_RESET) begin
                n.cnt = '0;
            end
            n.status_oe = 1'b1;
            n.done_oe = 1'b1;
            n.init_oe = 1'b0;
            n.arm = 1'b0;
            n.user_mode = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r <= CORE_RST;
        end else begin
            r <= n;
        end
    end

    // open-drain pins only ever pull low
    assign status_out = 1'b0;
    assign done_out = 1'b0;
    assign init_done_out = 1'b0;
    assign status_oe_out = r.status_oe;
    assign done_oe_out = r.done_oe;
    assign init_done_oe_out = r.init_oe;
    assign user_mode_out = r.user_mode;

    // ==========================================================
    // checks
    logic [CW-1:0] lo_cnt_r;
    logic [CW-1:0] hi_cnt_r;
    logic [CW-1:0] cd_cnt_r;
    logic [CW-1:0] ue_cnt_r;

    always_ff @(posedge clk_in or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            lo_cnt_r <= '0;
            hi_cnt_r <= '0;
            cd_cnt_r <= '0;
            ue_cnt_r <= '0;
        end else begin
            lo_cnt_r <= status_oe_out ? lo_cnt_r + 16'h0001 : '0;
            hi_cnt_r <= (status_oe_out && r.rcfg_s[1]) ? hi_cnt_r + 16'h0001 : '0;
            cd_cnt_r <= done_oe_out ? '0 : cd_cnt_r + 16'h0001;
            ue_cnt_r <= (r.st != PSL_INIT) ? '0 : ue_cnt_r + {15'h0000, uclk_edge};
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_sync_n);

    por_status_a: assert property (r.st == PSL_POR |-> status_oe_out && done_oe_out)
        else $error("status or load-complete released during power-on delay");
    load_low_a: assert property (r.st == PSL_LOAD && !r.done_s[1] |=> done_oe_out)
        else $error("load-complete released before image complete");
    done_cause_a: assert property ($fell(done_oe_out) |-> $past(r.done_s[1]) && $past(img_done, 2))
        else $error("load-complete rose without whole image");
    init_drive_a: assert property ($fell(init_done_oe_out)
                                   |-> user_mode_out || r.st == PSL_RESET)
        else $error("init-done released before user mode");
    cf_done_a: assert property ($fell(reconfig_n_in) && r.st != PSL_POR
                                |-> ##[1:CF2_CYC] done_oe_out)
        else $error("load-complete not low within 600 ns");
    cf_status_a: assert property ($fell(reconfig_n_in) && r.st != PSL_POR
                                  |-> ##[1:CF2_CYC] status_oe_out)
        else $error("status not low within 600 ns");
    sts_min_a: assert property ($fell(status_oe_out) |-> lo_cnt_r >= STS_MIN_CYC)
        else $error("status low pulse too short");
    sts_max_a: assert property (hi_cnt_r <= STATUS_MAX_CYC)
        else $error("status not released within 1506 us");
    um_osc_a: assert property ($rose(user_mode_out) && !r.use_uclk
                               |-> cd_cnt_r >= UM_MIN_CYC)
        else $error("user mode too early on internal oscillator");
    clk_en_a: assert property ($rose(r.st == PSL_INIT) && r.use_uclk
                               |-> cd_cnt_r >= CU_CYC)
        else $error("user clock enabled too early");
    init_len_a: assert property ($rose(user_mode_out) && r.use_uclk
                                 |-> ue_cnt_r == INIT_LAST + 16'h0001)
        else $error("initialization length wrong");
    user_high_a: assert property (user_mode_out |-> !status_oe_out && !done_oe_out
                                  && !init_done_oe_out)
        else $error("a line is low in user mode");

    user_osc_c: cover property ($rose(user_mode_out) && !r.use_uclk);
    user_uclk_c: cover property ($rose(user_mode_out) && r.use_uclk);
    reconfig_c: cover property (user_mode_out ##1 !user_mode_out && r.st == PSL_RESET);

endmodule

// >>> inc/psl_defs.svh
// timing counts, option bit positions and widths of the passive serial loader
`ifndef PSL_DEFS_SVH
`define PSL_DEFS_SVH

// ==========================================================
// clock and counter widths
`define PSL_CLK_NS 100
`define PSL_CNT_W 16
`define PSL_OPT_BITS 8

// ==========================================================
// option bits, first bits of the image, first bit in bit 0
`define PSL_OPT_INIT_DONE 0
`define PSL_OPT_USER_CLK 1

// ==========================================================
// timing, figures in their own unit and derived cycle counts
`define PSL_CF2ST0_NS 600
`define PSL_CF2ST0_CYC (`PSL_CF2ST0_NS / `PSL_CLK_NS)
`define PSL_STATUS_MIN_US 268
`define PSL_STATUS_MIN_CYC ((`PSL_STATUS_MIN_US * 1000 + `PSL_CLK_NS - 1) / `PSL_CLK_NS)
`define PSL_STATUS_MAX_US 1506
`define PSL_CD2UM_MIN_US 175
`define PSL_CD2UM_MIN_CYC ((`PSL_CD2UM_MIN_US * 1000 + `PSL_CLK_NS - 1) / `PSL_CLK_NS)
`define PSL_CD2UM_MAX_US 437
`define PSL_CONFIG_CLOCK_MAX_MHZ 125
`define PSL_CONFIG_CLOCK_MAX_PER_NS (1000 / `PSL_CONFIG_CLOCK_MAX_MHZ)
`define PSL_CD2CU_NS (4 * `PSL_CONFIG_CLOCK_MAX_PER_NS)
`define PSL_CD2CU_CYC ((`PSL_CD2CU_NS + `PSL_CLK_NS - 1) / `PSL_CLK_NS)
`define PSL_INIT_CYCLES 17408

`endif

// >>> inc/psl_pkg.sv
// types of the passive serial loader
package psl_pkg;

    typedef enum logic [2:0] {
        PSL_POR = 3'h0,
        PSL_RESET = 3'h1,
        PSL_LOAD = 3'h2,
        PSL_DONE = 3'h3,
        PSL_CLK_EN = 3'h4,
        PSL_INIT = 3'h5,
        PSL_USER = 3'h6
    } psl_state_t;

    typedef struct packed {
        psl_state_t st;
        logic [15:0] cnt;
        logic [15:0] ucnt;
        logic status_oe;
        logic done_oe;
        logic init_oe;
        logic arm;
        logic use_uclk;
        logic user_mode;
        logic [1:0] rcfg_s;
        logic [1:0] sts_s;
        logic [1:0] done_s;
        logic [1:0] go_s;
        logic [1:0] uclk_s;
        logic uclk_d;
    } psl_core_t;

    typedef struct packed {
        logic [31:0] bits;
        logic [7:0] opt;
        logic full;
    } psl_link_t;

endpackage

// >>> rtl/psl_link.sv
// config_clock domain: counts the image bits, shifts in the option bits and counts the trailing falling edges
`timescale 1ns/1ps
`include "psl_defs.svh"

module psl_link
    import psl_pkg::*;
#(
    parameter int IMAGE_BITS = 1024
) (
    input wire logic config_clock_in,
    input wire logic link_rst_n_in,
    input wire logic config_data_in,
    output logic image_done_out,
    output logic init_go_out,
    output logic [7:0] opt_out
);

    localparam logic [31:0] LAST_BIT = 32'(IMAGE_BITS - 1);
    localparam logic [31:0] OPT_N = 32'(`PSL_OPT_BITS);

    psl_link_t r;
    psl_link_t n;
    logic [1:0] fall_r;

    // ==========================================================
    // rising edge capture
    always_comb begin
        n = r;
        if (!r.full) begin
            n.bits = r.bits + 32'h00000001;
            if (r.bits < OPT_N) begin
                n.opt = {config_data_in, r.opt[7:1]};
            end
            if (r.bits == LAST_BIT) begin
                n.full = 1'b1;
            end
        end
    end

    always_ff @(posedge config_clock_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // the first falling edge after full closes the last bit; two more start initialization
    always_ff @(negedge config_clock_in or negedge link_rst_n_in) begin
        if (!link_rst_n_in) begin
            fall_r <= 2'h0;
        end else if (r.full && fall_r != 2'h3) begin
            fall_r <= fall_r + 2'h1;
        end
    end

    assign image_done_out = r.full;
    assign init_go_out = &fall_r;
    assign opt_out = r.opt;

endmodule

// >>> tb/psl_host_model.sv
// host side model: drives the serial clock and data into the loader
`timescale 1ns/1ps

module psl_host_model (
    output logic config_clock_out = 1'b0,
    output logic config_data_out = 1'b0
);
    // ==========================================================
    // clock stands low between calls and is never left floating
    task automatic send_bit(input logic b);
        config_data_out = b;
        #3 config_clock_out = 1'b1;
        #3 config_clock_out = 1'b0;
    endtask

    task automatic falling_edges(input int n);
        repeat (n) begin
            #3 config_clock_out = 1'b1;
            #3 config_clock_out = 1'b0;
        end
    endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench of the passive serial loader
`timescale 1ns/1ps

module tb_top;
    localparam int IB = 32;
    localparam int INIT_N = 16;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic reconfig_n_r = 1'b1;
    logic user_clk_r = 1'b0;
    logic st_o, st_oe, dn_o, dn_oe, in_o, in_oe, user_mode, cfg_clk, cfg_data;
    logic status_pin, done_pin, init_pin, bad;
    logic [31:0] rng = 32'hF4F2;
    logic [1:0] opt;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int uedges = 0;
    int n, u0;
    bit bq[$];

    // ==========================================================
    // open-drain pins with pull-ups
    assign status_pin = st_oe ? st_o : 1'b1;
    assign done_pin = dn_oe ? dn_o : 1'b1;
    assign init_pin = in_oe ? in_o : 1'b1;

    psl_loader #(.IMAGE_BITS(IB), .POR_CYCLES(20), .INIT_CYCLES(INIT_N)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .reconfig_n_in(reconfig_n_r),
        .status_in(status_pin), .status_out(st_o), .status_oe_out(st_oe),
        .done_in(done_pin), .done_out(dn_o), .done_oe_out(dn_oe),
        .init_done_out(in_o), .init_done_oe_out(in_oe),
        .config_clock_in(cfg_clk), .config_data_in(cfg_data),
        .user_init_clock_in(user_clk_r), .user_mode_out(user_mode));

    psl_host_model host (.config_clock_out(cfg_clk), .config_data_out(cfg_data));

    always #50 clk_in = ~clk_in;
    always #500 user_clk_r = ~user_clk_r;
    always @(posedge user_clk_r) uedges++;

    // ==========================================================
    // checking and closing
    task automatic report_and_stop();
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_lvl(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cyc(input int got, input int lo, input int hi);
        compares++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 96000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ==========================================================
    // one reconfiguration; k == 0 sends a short image and stops there
    task automatic config_run(input int k);
        int i;
        @(negedge clk_in);
        reconfig_n_r = 1'b0;
        repeat (6) @(negedge clk_in);
        chk_lvl(status_pin, 1'b0);
        chk_lvl(done_pin, 1'b0);
        chk_lvl(user_mode, 1'b0);
        repeat (19) @(negedge clk_in);
        reconfig_n_r = 1'b1;
        n = 25;
        while (status_pin !== 1'b1 && n < 16000) begin
            @(negedge clk_in);
            n++;
        end
        chk_cyc(n, 2680, 15085);
        repeat (15086 - n + 20) @(negedge clk_in);
        rng = xs(rng);
        opt = 2'(k - 1);
        bq = {};
        for (i = 0; i < IB; i++) begin
            bq.push_back(i < 2 ? opt[i] : rng[i]);
        end
        for (i = 0; i < IB - 1; i++) begin
            host.send_bit(bq[i]);
        end
        repeat (10) @(negedge clk_in);
        chk_lvl(done_pin, 1'b0);
        if (k == 0) return;
        host.send_bit(bq[IB - 1]);
        n = 0;
        while (done_pin !== 1'b1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        chk_cyc(n, 1, 8);
        u0 = uedges;
        n = 0;
        host.falling_edges(2);
        chk_lvl(init_pin, ~opt[0]);
        bad = 1'b0;
        while (user_mode !== 1'b1 && n < 6000) begin
            if (opt[0] && init_pin !== 1'b0) bad = 1'b1;
            @(negedge clk_in);
            n++;
        end
        chk_lvl(bad, 1'b0);
        if (opt[1]) begin
            chk_cyc(uedges - u0, INIT_N, INIT_N + 3);
        end else begin
            chk_cyc(n, 1750, 4370);
        end
        chk_lvl(status_pin & done_pin & init_pin, 1'b1);
    endtask

    initial begin
        repeat (10) @(negedge clk_in);
        rst_n_in = 1'b1;
        n = 0;
        while (status_pin !== 1'b1 && n < 3000) begin
            chk_lvl(done_pin, 1'b0);
            @(negedge clk_in);
            n++;
        end
        chk_cyc(n, 2680, 2700);
        for (int k = 0; k < 5; k++) begin
            config_run(k);
        end
        report_and_stop();
    end
endmodule
